//--- rtl/ues_map.svh
`ifndef UES_MAP_SVH
`define UES_MAP_SVH

// ==========================================================
// register byte offsets on the apb window
`define UES_OFS_STALL_LOW   8'h00
`define UES_OFS_STALL_HIGH  8'h04
`define UES_OFS_SETUP_PORT  8'h08
`define UES_OFS_CIN_PORT    8'h0c
`define UES_OFS_COUT_PORT   8'h10
`define UES_OFS_IIN_PORT    8'h14
`define UES_OFS_RX_SIZE     8'h18
`define UES_OFS_CTRL        8'h1c

// ==========================================================
// stall register fields
`define UES_STL_LOW_EP0     0
`define UES_STL_LOW_EP1I    3
`define UES_STL_LOW_EP2I    4
`define UES_STL_LOW_EP2O    5
`define UES_STL_LOW_EP3I    6
`define UES_STL_LOW_EP3O    7
`define UES_STL_LOW_WMASK   8'hf9
`define UES_STL_HIGH_EP4I   0
`define UES_STL_HIGH_EP4O   1
`define UES_STL_HIGH_EP5I   2
`define UES_STL_HIGH_WMASK  8'h87
`define UES_STL_HIGH_STLMSK 8'h07
`define UES_STL_CANCEL_ALL  8
`define UES_STL_RESET       8'h00

// ==========================================================
// control/status word fields
`define UES_CTRL_SETUP_FLAG 0
`define UES_CTRL_RDW_LSB    1
`define UES_RDW_RESET       2'h0

// ==========================================================
// sizes and reset values
`define UES_SETUP_BYTES     8
`define UES_PORT_RESET      8'h00
`define UES_RX_SIZE_BITS    7

`endif

//--- rtl/ues_pkg.sv
package ues_pkg;

  // answer given to a host token
  typedef enum logic [1:0] {
    UES_ANS_PASS,
    UES_ANS_STALL,
    UES_ANS_ZLP,
    UES_ANS_NONE
  } ues_ans_t;

  // apb access sequencer
  typedef enum logic [1:0] {
    UES_ST_IDLE,
    UES_ST_BYTE,
    UES_ST_DONE
  } ues_state_t;

endpackage

//--- rtl/ues_byte_buf.sv
`timescale 1ns/1ps
`include "ues_map.svh"

// byte queue behind one endpoint data port
module ues_byte_buf #(
  parameter int DEPTH = 64,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          clr,
  input  wire logic          push,
  input  wire logic [7:0]    push_data,
  input  wire logic          pop,
  output logic      [7:0]    pop_data,
  output logic      [CW-1:0] count,
  output logic               full,
  output logic               empty
);

  localparam int AW = $clog2(DEPTH);

  if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0)) begin : g_bad_depth
    $error("ues_byte_buf depth must be a power of two, at least 2");
  end

  logic [7:0]    mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic          do_push;
  logic          do_pop;

  // =========================================================
  // pointer guards: overflow drops, underflow returns zero
  assign full     = (cnt_q == CW'(DEPTH));
  assign empty    = (cnt_q == '0);
  assign do_push  = push & ~full & ~clr;
  assign do_pop   = pop & ~empty & ~clr;
  assign pop_data = empty ? `UES_PORT_RESET : mem_q[rd_q];
  assign count    = cnt_q;

  // storage has no reset, only valid entries are ever read
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end

endmodule

//--- rtl/ues_endpoint_ctrl.sv
`timescale 1ns/1ps
`include "ues_map.svh"

module ues_endpoint_ctrl
  import ues_pkg::*;
#(
  parameter int EP0_IN_DEPTH  = 64,
  parameter int EP1_IN_DEPTH  = 64,
  parameter int EP0_OUT_DEPTH = 64
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // token side, from the serial engine on this clock
  input  wire logic        tok_valid,
  input  wire logic [3:0]  tok_ep,
  input  wire logic        tok_in,
  input  wire logic        tok_setup,
  output logic             ans_valid,
  output ues_ans_t         ans_code,
  // setup stage bytes
  input  wire logic        setup_start,
  input  wire logic        setup_byte_valid,
  input  wire logic [7:0]  setup_byte,
  input  wire logic        setup_end,
  // control-out data from the host
  input  wire logic        out_byte_valid,
  input  wire logic [7:0]  out_byte,
  // control-in and interrupt-in data toward the host
  input  wire logic        ep0_in_pop,
  output logic             ep0_in_valid,
  output logic      [7:0]  ep0_in_byte,
  input  wire logic        ep1_in_pop,
  output logic             ep1_in_valid,
  output logic      [7:0]  ep1_in_byte
);

  localparam int C0W = $clog2(EP0_IN_DEPTH) + 1;
  localparam int C1W = $clog2(EP1_IN_DEPTH) + 1;
  localparam int COW = $clog2(EP0_OUT_DEPTH) + 1;
  localparam int CSW = $clog2(`UES_SETUP_BYTES) + 1;

  if (EP0_OUT_DEPTH > 64) begin : g_bad_out
    $error("control-out depth must fit the 7-bit receive size");
  end

  // ==========================================================
  // state
  ues_state_t  state_q;
  logic [1:0]  idx_q;
  logic [31:0] rdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [7:0]  stall_low_q;
  logic [7:0]  stall_low_d;
  logic [7:0]  stall_high_q;
  logic [7:0]  stall_high_d;
  logic        setup_flag_q;
  logic [1:0]  rd_width_q;
  logic        iso_zlp_done_q;
  logic        ans_valid_q;
  ues_ans_t    ans_code_q;
  ues_ans_t    ans_code_d;
  logic        ep0_in_valid_q;
  logic [7:0]  ep0_in_byte_q;
  logic        ep1_in_valid_q;
  logic [7:0]  ep1_in_byte_q;

  // ==========================================================
  // address decode
  wire sel_low   = (paddr == `UES_OFS_STALL_LOW);
  wire sel_high  = (paddr == `UES_OFS_STALL_HIGH);
  wire sel_setup = (paddr == `UES_OFS_SETUP_PORT);
  wire sel_cin   = (paddr == `UES_OFS_CIN_PORT);
  wire sel_cout  = (paddr == `UES_OFS_COUT_PORT);
  wire sel_iin   = (paddr == `UES_OFS_IIN_PORT);
  wire sel_size  = (paddr == `UES_OFS_RX_SIZE);
  wire sel_ctrl  = (paddr == `UES_OFS_CTRL);
  wire sel_port  = sel_setup | sel_cin | sel_cout | sel_iin;
  wire mapped    = sel_port | sel_low | sel_high | sel_size | sel_ctrl;
  wire setup_ph  = psel & ~penable & (state_q == UES_ST_IDLE);

  // the write lands on the edge where the master sees pready
  wire reg_wr    = psel & penable & pwrite & (state_q == UES_ST_DONE);
  wire wr_low    = reg_wr & sel_low & pstrb[0];
  wire wr_high   = reg_wr & sel_high & pstrb[0];
  wire wr_ctrl   = reg_wr & sel_ctrl & pstrb[0];
  wire cancel_all = reg_wr & sel_high & pstrb[1] & pwdata[`UES_STL_CANCEL_ALL];

  // ==========================================================
  // byte lane sequencing for data ports
  wire [1:0] rd_last  = (rd_width_q == 2'h0) ? 2'h0 :
                        (rd_width_q == 2'h1) ? 2'h1 : 2'h3;
  wire       lane_on  = pwrite ? pstrb[idx_q] : (idx_q <= rd_last);
  wire       byte_go  = (state_q == UES_ST_BYTE) & lane_on;
  wire [7:0] lane_wd  = pwdata[8*idx_q +: 8];
  wire       setup_pop = byte_go & sel_setup & ~pwrite;
  wire       cout_pop  = byte_go & sel_cout & ~pwrite;
  wire       cin_push  = byte_go & sel_cin & pwrite;
  wire       iin_push  = byte_go & sel_iin & pwrite;

  // ==========================================================
  // endpoint buffers
  logic [7:0]     setup_pd;
  logic [CSW-1:0] setup_cnt;
  logic [7:0]     cout_pd;
  logic [COW-1:0] cout_cnt;
  logic [7:0]     cin_pd;
  logic           cin_empty;
  logic [7:0]     iin_pd;
  logic           iin_empty;

  // a fresh setup stage discards any unread command bytes
  ues_byte_buf #(.DEPTH(`UES_SETUP_BYTES)) u_setup_buf (
    .clk       (clk),
    .rst       (rst),
    .clr       (setup_start),
    .push      (setup_byte_valid),
    .push_data (setup_byte),
    .pop       (setup_pop),
    .pop_data  (setup_pd),
    .count     (setup_cnt),
    .full      (),
    .empty     ()
  );

  ues_byte_buf #(.DEPTH(EP0_OUT_DEPTH)) u_cout_buf (
    .clk       (clk),
    .rst       (rst),
    .clr       (1'b0),
    .push      (out_byte_valid),
    .push_data (out_byte),
    .pop       (cout_pop),
    .pop_data  (cout_pd),
    .count     (cout_cnt),
    .full      (),
    .empty     ()
  );

  ues_byte_buf #(.DEPTH(EP0_IN_DEPTH)) u_cin_buf (
    .clk       (clk),
    .rst       (rst),
    .clr       (1'b0),
    .push      (cin_push),
    .push_data (lane_wd),
    .pop       (ep0_in_pop),
    .pop_data  (cin_pd),
    .count     (),
    .full      (),
    .empty     (cin_empty)
  );

  ues_byte_buf #(.DEPTH(EP1_IN_DEPTH)) u_iin_buf (
    .clk       (clk),
    .rst       (rst),
    .clr       (1'b0),
    .push      (iin_push),
    .push_data (lane_wd),
    .pop       (ep1_in_pop),
    .pop_data  (iin_pd),
    .count     (),
    .full      (),
    .empty     (iin_empty)
  );

  // ==========================================================
  // register read data; write-only ports read as zero
  wire [7:0] lane_rd = sel_setup ? setup_pd : sel_cout ? cout_pd : `UES_PORT_RESET;
  wire [6:0] rx_size = `UES_RX_SIZE_BITS'(cout_cnt);
  wire [31:0] reg_rd = sel_low  ? {24'h000000, stall_low_q} :
                       sel_high ? {24'h000000, stall_high_q} :
                       sel_size ? {25'h0000000, rx_size} :
                       sel_ctrl ? {29'h00000000, rd_width_q, setup_flag_q} :
                       32'h00000000;

  // ==========================================================
  // apb sequencer: ports take four byte slots, others answer at once
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= UES_ST_IDLE;
      idx_q     <= 2'h0;
      rdata_q   <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      case (state_q)
        UES_ST_IDLE: begin
          if (setup_ph) begin
            idx_q     <= 2'h0;
            rdata_q   <= reg_rd;
            pslverr_q <= ~mapped;
            state_q   <= sel_port ? UES_ST_BYTE : UES_ST_DONE;
            pready_q  <= ~sel_port;
          end
        end
        UES_ST_BYTE: begin
          if (!pwrite) begin
            rdata_q[8*idx_q +: 8] <= lane_on ? lane_rd : 8'h00;
          end
          idx_q <= idx_q + 2'h1;
          if (idx_q == 2'h3) begin
            state_q  <= UES_ST_DONE;
            pready_q <= 1'b1;
          end
        end
        default: begin
          state_q   <= UES_ST_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // stall bits; they change only by write, cancel or setup
  always_comb begin
    stall_low_d  = stall_low_q;
    stall_high_d = stall_high_q;
    if (cancel_all) begin
      stall_low_d  = `UES_STL_RESET;
      stall_high_d = stall_high_q & ~`UES_STL_HIGH_STLMSK;
    end
    if (wr_low) begin
      stall_low_d = pwdata[7:0] & `UES_STL_LOW_WMASK;
      if (setup_flag_q && pwdata[`UES_STL_LOW_EP0]) begin
        stall_low_d[`UES_STL_LOW_EP0] = stall_low_q[`UES_STL_LOW_EP0];
      end
    end
    if (wr_high) begin
      stall_high_d = pwdata[7:0] & `UES_STL_HIGH_WMASK;
    end
    // hardware clear outranks a software write in the same cycle
    if (setup_end) begin
      stall_low_d[`UES_STL_LOW_EP0] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stall_low_q  <= `UES_STL_RESET;
      stall_high_q <= `UES_STL_RESET;
    end else begin
      stall_low_q  <= stall_low_d;
      stall_high_q <= stall_high_d;
    end
  end

  // setup flag: set on a completed setup stage, write 1 clears, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      setup_flag_q <= 1'b0;
      rd_width_q   <= `UES_RDW_RESET;
    end else begin
      if (setup_end) begin
        setup_flag_q <= 1'b1;
      end else if (wr_ctrl && pwdata[`UES_CTRL_SETUP_FLAG]) begin
        setup_flag_q <= 1'b0;
      end
      if (wr_ctrl) begin
        rd_width_q <= pwdata[`UES_CTRL_RDW_LSB +: 2];
      end
    end
  end

  // ==========================================================
  // token answers
  wire iso_in_stl  = stall_low_q[`UES_STL_LOW_EP3I];
  wire iso_out_stl = stall_low_q[`UES_STL_LOW_EP3O];
  wire ep_stalled  =
    (tok_ep == 4'h0) ? stall_low_q[`UES_STL_LOW_EP0] :
    (tok_ep == 4'h1) ? (tok_in & stall_low_q[`UES_STL_LOW_EP1I]) :
    (tok_ep == 4'h2) ? (tok_in ? stall_low_q[`UES_STL_LOW_EP2I]
                               : stall_low_q[`UES_STL_LOW_EP2O]) :
    (tok_ep == 4'h4) ? (tok_in ? stall_high_q[`UES_STL_HIGH_EP4I]
                               : stall_high_q[`UES_STL_HIGH_EP4O]) :
    (tok_ep == 4'h5) ? (tok_in & stall_high_q[`UES_STL_HIGH_EP5I]) :
    1'b0;
  wire is_iso      = (tok_ep == 4'h3);

  // setup tokens are always accepted so a stalled pipe can recover
  always_comb begin
    ans_code_d = UES_ANS_PASS;
    if (tok_setup) begin
      ans_code_d = UES_ANS_PASS;
    end else if (is_iso) begin
      if (tok_in && iso_in_stl) begin
        ans_code_d = iso_zlp_done_q ? UES_ANS_NONE : UES_ANS_ZLP;
      end else if (!tok_in && iso_out_stl) begin
        ans_code_d = UES_ANS_NONE;
      end
    end else if (ep_stalled) begin
      ans_code_d = UES_ANS_STALL;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ans_valid_q    <= 1'b0;
      ans_code_q     <= UES_ANS_PASS;
      iso_zlp_done_q <= 1'b0;
    end else begin
      ans_valid_q <= tok_valid;
      if (tok_valid) begin
        ans_code_q <= ans_code_d;
      end
      // the zero-length reply is armed again once the stall is lifted
      if (!iso_in_stl) begin
        iso_zlp_done_q <= 1'b0;
      end else if (tok_valid && !tok_setup && is_iso && tok_in) begin
        iso_zlp_done_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // in data toward the serial engine, one cycle after the pop
  always_ff @(posedge clk) begin
    if (rst) begin
      ep0_in_valid_q <= 1'b0;
      ep0_in_byte_q  <= `UES_PORT_RESET;
      ep1_in_valid_q <= 1'b0;
      ep1_in_byte_q  <= `UES_PORT_RESET;
    end else begin
      ep0_in_valid_q <= ep0_in_pop & ~cin_empty;
      ep1_in_valid_q <= ep1_in_pop & ~iin_empty;
      if (ep0_in_pop && !cin_empty) begin
        ep0_in_byte_q <= cin_pd;
      end
      if (ep1_in_pop && !iin_empty) begin
        ep1_in_byte_q <= iin_pd;
      end
    end
  end

  // ==========================================================
  // outputs, all from flops
  assign prdata       = rdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign ans_valid    = ans_valid_q;
  assign ans_code     = ans_code_q;
  assign ep0_in_valid = ep0_in_valid_q;
  assign ep0_in_byte  = ep0_in_byte_q;
  assign ep1_in_valid = ep1_in_valid_q;
  assign ep1_in_byte  = ep1_in_byte_q;

endmodule

//--- dv/ues_ctrl_properties.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the endpoint control block
module ues_ctrl_checker
  import ues_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       tok_valid,
  input wire logic [3:0] tok_ep,
  input wire logic       tok_in,
  input wire logic       tok_setup,
  input wire logic       ans_valid,
  input wire ues_ans_t   ans_code,
  input wire logic       ep0_in_pop,
  input wire logic       ep0_in_valid,
  input wire logic       ep1_in_pop,
  input wire logic       ep1_in_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================
  // apb answer timing
  sequence reg_setup;
    psel && !penable && paddr inside {8'h00, 8'h04, 8'h18, 8'h1c};
  endsequence
  sequence port_setup;
    psel && !penable && paddr inside {8'h08, 8'h0c, 8'h10, 8'h14};
  endsequence
  // data ports spend four byte slots before answering
  sequence port_wait;
    !pready [*4] ##1 pready;
  endsequence
  reg_answer_a: assert property (reg_setup |=> pready)
    else $error("register access not answered next cycle");
  port_answer_a: assert property (port_setup |=> port_wait)
    else $error("data port answer timing wrong");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");

  // ==========================================
  // token answers
  ans_delay_a: assert property (tok_valid |=> ans_valid)
    else $error("token not answered one cycle later");
  ans_cause_a: assert property (ans_valid |-> $past(tok_valid))
    else $error("answer without a token");
  iso_never_a: assert property (tok_valid && tok_ep == 4'h3 |=> ans_code != UES_ANS_STALL)
    else $error("isochronous endpoint sent a stall");
  iso_quiet_a: assert property (ans_valid && ans_code inside {UES_ANS_ZLP, UES_ANS_NONE}
    |-> $past(tok_ep) == 4'h3)
    else $error("empty or missing reply off endpoint 3");
  setup_pass_a: assert property (tok_valid && tok_setup |=> ans_code == UES_ANS_PASS)
    else $error("setup token not passed");
  in0_cause_a: assert property (ep0_in_valid |-> $past(ep0_in_pop))
    else $error("control-in byte without a pop");
  in1_cause_a: assert property (ep1_in_valid |-> $past(ep1_in_pop))
    else $error("interrupt-in byte without a pop");
endmodule

bind ues_endpoint_ctrl ues_ctrl_checker chk_u (.clk, .rst, .psel, .penable, .paddr, .pready,
  .tok_valid, .tok_ep, .tok_in, .tok_setup, .ans_valid, .ans_code, .ep0_in_pop, .ep0_in_valid,
  .ep1_in_pop, .ep1_in_valid);

//--- dv/ues_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host side: tokens, setup and out bytes, in pops
module ues_host_model
  import ues_pkg::*;
(
  input  wire logic       clk,
  output logic            tok_valid,
  output logic [3:0]      tok_ep,
  output logic            tok_in,
  output logic            tok_setup,
  input  wire logic       ans_valid,
  input  wire ues_ans_t   ans_code,
  output logic            setup_start,
  output logic            setup_byte_valid,
  output logic [7:0]      setup_byte,
  output logic            setup_end,
  output logic            out_byte_valid,
  output logic [7:0]      out_byte,
  output logic            ep0_in_pop,
  output logic            ep1_in_pop,
  input  wire logic       ep0_in_valid,
  input  wire logic [7:0] ep0_in_byte,
  input  wire logic       ep1_in_valid,
  input  wire logic [7:0] ep1_in_byte
);
  // idle at time zero
  initial begin
    {tok_valid, tok_ep, tok_in, tok_setup, setup_start, setup_end} = '0;
    {setup_byte_valid, setup_byte, out_byte_valid, out_byte, ep0_in_pop, ep1_in_pop} = '0;
  end

  // released qualifiers carry the inverse so stale values never match
  task automatic token(input logic [3:0] ep, input logic din, input logic st,
                       output logic [31:0] r);
    tok_valid <= 1; tok_ep <= ep; tok_in <= din; tok_setup <= st;
    @(posedge clk); tok_valid <= 0; tok_ep <= ~ep; tok_in <= ~din; tok_setup <= ~st;
    @(posedge clk); r = ans_valid ? {30'h0, ans_code} : 32'hffffffff;
  endtask
  // kind 0 setup byte, 1 control-out byte
  task automatic send(input int kind, input logic [7:0] b);
    if (kind == 0) begin setup_byte_valid <= 1; setup_byte <= b; end
    else begin out_byte_valid <= 1; out_byte <= b; end
    @(posedge clk); setup_byte_valid <= 0; out_byte_valid <= 0;
    setup_byte <= ~b; out_byte <= ~b;
    @(posedge clk);
  endtask
  // kind 0 setup start, 1 setup end
  task automatic mark(input int kind);
    if (kind == 0) setup_start <= 1; else setup_end <= 1;
    @(posedge clk); setup_start <= 0; setup_end <= 0;
    @(posedge clk);
  endtask
  // an empty buffer gives no valid, reported as all ones
  task automatic pop(input int ep, output logic [31:0] r);
    if (ep == 0) ep0_in_pop <= 1; else ep1_in_pop <= 1;
    @(posedge clk); ep0_in_pop <= 0; ep1_in_pop <= 0;
    @(posedge clk);
    if (ep == 0) r = ep0_in_valid ? {24'h0, ep0_in_byte} : 32'hffffffff;
    else r = ep1_in_valid ? {24'h0, ep1_in_byte} : 32'hffffffff;
  endtask
endmodule

//--- dv/test_ues_endpoint_ctrl.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench with a queue model
module test_ues_endpoint_ctrl
  import ues_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, r;
  logic [3:0] pstrb;
  logic tok_valid, tok_in, tok_setup, ans_valid, setup_start, setup_byte_valid, setup_end;
  logic out_byte_valid, ep0_in_pop, ep0_in_valid, ep1_in_pop, ep1_in_valid, rerr;
  logic [3:0] tok_ep;
  logic [7:0] setup_byte, out_byte, ep0_in_byte, ep1_in_byte;
  ues_ans_t ans_code;
  int error_cnt, n_tests, lo, hi, zlp, sflag, v, w;
  int sq[$], iq0[$], iq1[$], oq[$];

  ues_endpoint_ctrl dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .tok_valid, .tok_ep, .tok_in, .tok_setup, .ans_valid,
    .ans_code, .setup_start, .setup_byte_valid, .setup_byte, .setup_end, .out_byte_valid,
    .out_byte, .ep0_in_pop, .ep0_in_valid, .ep0_in_byte, .ep1_in_pop, .ep1_in_valid,
    .ep1_in_byte);
  ues_host_model host_u (.clk, .tok_valid, .tok_ep, .tok_in, .tok_setup, .ans_valid,
    .ans_code, .setup_start, .setup_byte_valid, .setup_byte, .setup_end, .out_byte_valid,
    .out_byte, .ep0_in_pop, .ep1_in_pop, .ep0_in_valid, .ep0_in_byte, .ep1_in_valid,
    .ep1_in_byte);

  // ==========================================
  // clock, 40 ns
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // apb master; an extra idle edge keeps psel single-driven per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk); penable <= 1;
    // no cycle budget here: a slave that never answers is caught by the watchdog
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata; rerr = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic wlo(int d);
    apb(1, 8'h00, 32'(d), 4'h1);
    d &= 'hf9;
    if (sflag && (d & 1)) d = (d & 'hf8) | (lo & 1);
    if (!(d >> 6 & 1)) zlp = 0;
    lo = d;
  endtask
  task automatic whi(int d);
    apb(1, 8'h04, 32'(d), 4'h1);
    hi = d & 'h87;
  endtask
  // n bytes off the front of a queue, byte k in lane k
  task automatic take(inout int q[$], input int n, output logic [31:0] x);
    x = 0;
    for (int k = 0; k < n; k++) x[8*k +: 8] = 8'(q.pop_front());
  endtask
  // expected answer code to a token
  function automatic int ans_of(int ep, int din);
    int b;
    b = 0;
    case (ep)
      0: b = lo & 1;
      1: b = din ? lo >> 3 & 1 : 0;
      2: b = lo >> (din ? 4 : 5) & 1;
      4: b = hi >> (1 - din) & 1;
      5: b = din ? hi >> 2 & 1 : 0;
      3: begin
        if (!din) return (lo >> 7 & 1) ? 3 : 0;
        if (!(lo >> 6 & 1)) return 0;
        b = zlp;
        zlp = 1;
        return b ? 3 : 2;
      end
    endcase
    return b;
  endfunction

  // ==========================================
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end

  // ==========================================
  // main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = '1;
    {psel, penable} = '0;
    v = $urandom(2790);
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk(ep0_in_byte, 0);
    apb(0, 8'h00, 0, 0); chk(rdat, 0);
    apb(0, 8'h04, 0, 0); chk(rdat, 0);
    for (int i = 0; i < 5; i++) begin
      v = (i == 4) ? 'hff : $urandom & 'hff;
      wlo(v); apb(0, 8'h00, 0, 0); chk(rdat, lo);
      whi(v & 'h7f); apb(0, 8'h04, 0, 0); chk(rdat, hi);
    end
    for (int e = 0; e < 7; e++)
      for (int d = 0; d < 2; d++) begin
        host_u.token(4'(e % 6), d[0], 1'b0, r); chk(r, ans_of(e % 6, d));
      end
    host_u.token(4'h3, 1'b1, 1'b0, r); chk(r, ans_of(3, 1));
    host_u.token(4'h0, 1'b0, 1'b1, r); chk(r, 0);
    apb(1, 8'h04, 32'h100, 4'h2); lo = 0; hi &= 'h80; zlp = 0;
    apb(0, 8'h00, 0, 0); chk(rdat, lo);
    apb(0, 8'h04, 0, 0); chk(rdat, hi);
    host_u.token(4'h2, 1'b1, 1'b0, r); chk(r, 0);
    // setup stage while endpoint 0 is stalled
    wlo(1);
    host_u.mark(0);
    for (int i = 0; i < 8; i++) begin
      v = $urandom & 'hff; sq.push_back(v); host_u.send(0, 8'(v));
    end
    host_u.mark(1); sflag = 1; lo &= 'hfe;
    apb(0, 8'h00, 0, 0); chk(rdat, lo);
    wlo(1); apb(0, 8'h00, 0, 0); chk(rdat, lo);
    apb(1, 8'h1c, 32'h4, 4'h1);
    for (int i = 0; i < 2; i++) begin
      apb(0, 8'h08, 0, 0); take(sq, 4, r); chk(rdat, r);
    end
    apb(1, 8'h1c, 32'h5, 4'h1); sflag = 0;
    wlo(1); apb(0, 8'h00, 0, 0); chk(rdat, 1);
    // in ports: longword and word writes, read-back gives zero
    v = $urandom; apb(1, 8'h0c, 32'(v), 4'hf);
    for (int k = 0; k < 4; k++) iq0.push_back(v >> 8*k & 'hff);
    w = $urandom; apb(1, 8'h14, 32'(w), 4'h3);
    for (int k = 0; k < 2; k++) iq1.push_back(w >> 8*k & 'hff);
    apb(0, 8'h0c, 0, 0); chk(rdat, 0);
    for (int i = 0; i < 5; i++) begin
      host_u.pop(0, r); chk(r, iq0.size() ? iq0.pop_front() : 32'hffffffff);
    end
    for (int i = 0; i < 3; i++) begin
      host_u.pop(1, r); chk(r, iq1.size() ? iq1.pop_front() : 32'hffffffff);
    end
    // control-out: word then longword reads drain the count
    for (int i = 0; i < 6; i++) begin
      v = $urandom & 'hff; oq.push_back(v); host_u.send(1, 8'(v));
    end
    apb(0, 8'h18, 0, 0); chk(rdat, 6);
    apb(1, 8'h1c, 32'h2, 4'h1);
    apb(0, 8'h10, 0, 0); take(oq, 2, r); chk(rdat, r);
    apb(0, 8'h18, 0, 0); chk(rdat, 4);
    apb(1, 8'h1c, 32'h4, 4'h1);
    apb(0, 8'h10, 0, 0); take(oq, 4, r); chk(rdat, r);
    apb(0, 8'h18, 0, 0); chk(rdat, 0);
    apb(0, 8'h20, 0, 0); chk({31'h0, rerr}, 1);
    chk(rdat, 0);
    give_verdict;
  end
endmodule
